// ### hw/mlu_map.vh
`ifndef MLU_MAP_VH
`define MLU_MAP_VH
// ----------------------------------------
// Opcodes of the load family
// ----------------------------------------
`define MLU_OP_WORD         8'h90
`define MLU_OP_UBYTE        8'h80
`define MLU_OP_UHALF        8'h88
`define MLU_OP_SBYTE        8'hC0
`define MLU_OP_SHALF        8'hC8
`define MLU_OP_DWORD        8'h98
`define MLU_OP_TWORD        8'hA0
`define MLU_OP_QWORD        8'hB0
`define MLU_OP_ADDR         8'h8C
// ----------------------------------------
// Widths and steps
// ----------------------------------------
`define MLU_WORD_STEP       32'h0000_0004
`define MLU_FILL_ONES16     16'hFFFF
`define MLU_FILL_ZERO16     16'h0000
`define MLU_FILL_ONES24     24'hFFFFFF
`define MLU_FILL_ZERO24     24'h000000
`define MLU_CNT_ONE         3'h1
`define MLU_CNT_TWO         3'h2
`define MLU_CNT_THREE       3'h3
`define MLU_CNT_FOUR        3'h4
// ----------------------------------------
// Alignment masks and register steps
// ----------------------------------------
`define MLU_ALIGN_HALF      32'h0000_0001
`define MLU_ALIGN_WORD      32'h0000_0003
`define MLU_ALIGN_DWORD     32'h0000_0007
`define MLU_ALIGN_QUAD      32'h0000_000F
`define MLU_DST_PAIR        5'h01
`define MLU_DST_QUAD        5'h03
`define MLU_REG_STEP        5'h01
// Kind codes from the decoder
`define MLU_K_NONE          4'h0
`define MLU_K_WORD          4'h1
`define MLU_K_UBYTE         4'h2
`define MLU_K_UHALF         4'h3
`define MLU_K_SBYTE         4'h4
`define MLU_K_SHALF         4'h5
`define MLU_K_DWORD         4'h6
`define MLU_K_TWORD         4'h7
`define MLU_K_QWORD         4'h8
`define MLU_K_ADDR          4'h9
`endif

// ### hw/mlu_decode.v
`timescale 1ns/1ps
`include "mlu_map.vh"
// ----------------------------------------
// Opcode decoder of the load family
// ----------------------------------------
module mlu_decode (
    // Opcode
    input  wire [7:0] opcode_in,
    // Decoded kind and word count
    output reg  [3:0] kind_out,
    output reg  [2:0] count_out
);
    // Map opcode to kind and word count
    always @* begin
        kind_out  = `MLU_K_NONE;
        count_out = `MLU_CNT_ONE;
        case (opcode_in)
            `MLU_OP_WORD:  kind_out = `MLU_K_WORD;
            `MLU_OP_UBYTE: kind_out = `MLU_K_UBYTE;
            `MLU_OP_UHALF: kind_out = `MLU_K_UHALF;
            `MLU_OP_SBYTE: kind_out = `MLU_K_SBYTE;
            `MLU_OP_SHALF: kind_out = `MLU_K_SHALF;
            `MLU_OP_DWORD: begin
                kind_out  = `MLU_K_DWORD;
                count_out = `MLU_CNT_TWO;
            end
            `MLU_OP_TWORD: begin
                kind_out  = `MLU_K_TWORD;
                count_out = `MLU_CNT_THREE;
            end
            `MLU_OP_QWORD: begin
                kind_out  = `MLU_K_QWORD;
                count_out = `MLU_CNT_FOUR;
            end
            `MLU_OP_ADDR:  kind_out = `MLU_K_ADDR;
            default:       kind_out = `MLU_K_NONE;
        endcase
    end
endmodule

// ### hw/mlu_extend.v
`timescale 1ns/1ps
`include "mlu_map.vh"
// ----------------------------------------
// Widening of byte and halfword data
// ----------------------------------------
module mlu_extend (
    // Raw word and kind
    input  wire [31:0] data_in,
    input  wire [3:0]  kind_in,
    // Widened word
    output reg  [31:0] data_out
);
    // Select extension by kind
    always @* begin
        data_out = data_in;
        case (kind_in)
            `MLU_K_UBYTE: data_out = {`MLU_FILL_ZERO24, data_in[7:0]};
            `MLU_K_SBYTE: data_out = data_in[7] ?
                {`MLU_FILL_ONES24, data_in[7:0]} :
                {`MLU_FILL_ZERO24, data_in[7:0]};
            `MLU_K_UHALF: data_out = {`MLU_FILL_ZERO16, data_in[15:0]};
            `MLU_K_SHALF: data_out = data_in[15] ?
                {`MLU_FILL_ONES16, data_in[15:0]} :
                {`MLU_FILL_ZERO16, data_in[15:0]};
            default:      data_out = data_in;
        endcase
    end
endmodule

// ### hw/mlu_load_unit.v
// Function
// - Signed half fills upper bits with sign
// - Odd double destination gives bad operand
// - Double loads two words, checks 8-alignment
// - Triple/quad destination must be multiple of four
// - Triple/quad fault unless 16-byte aligned
// - Triple/quad fill three/four consecutive registers
// - Opcodes C0H, C8H, 98H decoded
// - Opcodes A0H, B0H decoded
// - Load address writes address, no memory
// - Load address takes any addressing mode
// - Byte/half widen: sign or zero
`timescale 1ns/1ps
`include "mlu_map.vh"
module mlu_load_unit (
    // Clock and reset
    input  wire        ref_clk_in,
    input  wire        nrst_in,
    // Instruction issue
    input  wire        issue_valid_in,
    input  wire [7:0]  opcode_in,
    input  wire [4:0]  dst_reg_in,
    input  wire [31:0] eff_addr_in,
    input  wire        unaligned_en_in,
    // Memory read port
    output wire        mem_req_out,
    output wire [31:0] mem_addr_out,
    input  wire        mem_ack_in,
    input  wire [31:0] mem_data_in,
    // Register file write port
    output wire        rf_we_out,
    output wire [4:0]  rf_waddr_out,
    output wire [31:0] rf_wdata_out,
    // Status and faults
    output wire        busy_out,
    output wire        done_out,
    output wire        bad_operand_fault_out,
    output wire        misaligned_access_fault_out
);
    // ----------------------------------------
    // Operation notes
    // ----------------------------------------
    // Issue is taken on a rising edge with issue_valid_in high,
    // busy_out low and an opcode the decoder knows. Unknown
    // opcodes and any issue while busy are dropped silently,
    // so the caller must wait for busy_out low before the next
    // multi-cycle load.
    //
    // Address load: the effective address arrives fully formed,
    // so every addressing mode looks the same here. It is
    // written to the destination one cycle after issue with
    // done_out in the same cycle. No memory request is made
    // and the address is never checked.
    //
    // Bad operand: a double load with an odd destination, or a
    // triple or quad load whose destination is not a multiple
    // of four, is refused at issue. The fault pulse and done
    // pulse appear one cycle later; no request is raised and
    // the register file is not written.
    //
    // Memory loads: the request rises one cycle after issue
    // with the effective address. Each acknowledge writes one
    // register on the next cycle, steps the address by four
    // and the destination by one. The request falls with the
    // last acknowledge.
    //
    // Completion: done_out pulses one cycle after the last
    // register write, in the same cycle busy_out falls. A
    // misalignment found at issue is held until then and
    // reported with done_out, so the loaded data is already
    // in the register file when the fault is seen.
    //
    // Alignment: single words need bits 1:0 clear, halfwords
    // bit 0, doubles bits 2:0 and triples and quads bits 3:0.
    // Bytes never fault. The check is only acted on when
    // unaligned_en_in is high at issue.
    //
    // Widening: byte and halfword data is taken from the low
    // lanes of mem_data_in; the memory side is expected to
    // return the addressed unit there. No lane shifting is
    // done in this block.
    //
    // Register numbers: the destination counter is five bits
    // wide and wraps past the last register. Software keeps
    // groups inside the register file; nothing here checks it.
    //
    // Hazards: mem_ack_in is only looked at in the read state,
    // so a late acknowledge after reset or after the last word
    // is ignored. The memory side must not acknowledge twice
    // for one address: each acknowledge consumes one word.
    //
    // Reset is synchronous and clears every output register,
    // so all outputs read zero during reset and on the first
    // edge after release.
    //
    // Status: busy_out is registered from the next state so
    // that every output leaves a flip-flop; it reads high from
    // the cycle after a memory load issues up to the cycle before done_out.

    // ----------------------------------------
    // State encoding
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;   // Waiting for issue
    localparam [2:0] ST_READ = 3'h2;   // Reading words
    localparam [2:0] ST_DONE = 3'h4;   // Finishing

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [2:0]  state_reg,    state_next;    // Control state
    reg [3:0]  kind_reg,     kind_next;     // Latched kind
    reg [2:0]  left_reg,     left_next;     // Words still to read
    reg [31:0] addr_reg,     addr_next;     // Current address
    reg [4:0]  reg_reg,      reg_next;      // Current destination
    reg        mis_reg,      mis_next;      // Pending misalign fault
    reg        req_reg,      req_next;      // Memory request
    reg        we_reg,       we_next;       // Register write
    reg [4:0]  waddr_reg,    waddr_next;    // Write address
    reg [31:0] wdata_reg,    wdata_next;    // Write data
    reg        done_reg,     done_next;     // Completion pulse
    reg        bad_reg,      bad_next;      // Bad operand pulse
    reg        misf_reg,     misf_next;     // Misalign fault pulse
    reg        busy_reg,     busy_next;     // Busy flag

    // ----------------------------------------
    // Decode and widen
    // ----------------------------------------
    wire [3:0]  dec_kind;     // Kind of issued opcode
    wire [2:0]  dec_count;    // Words of issued opcode
    wire [31:0] ext_data;     // Widened memory data

    mlu_decode u_dec (
        .opcode_in (opcode_in),
        .kind_out  (dec_kind),
        .count_out (dec_count)
    );

    mlu_extend u_ext (
        .data_in  (mem_data_in),
        .kind_in  (kind_reg),
        .data_out (ext_data)
    );

    // ----------------------------------------
    // Issue checks
    // ----------------------------------------
    // odd register for double
    wire dst_odd  = |(dst_reg_in & `MLU_DST_PAIR);
    wire dst_nq   = |(dst_reg_in & `MLU_DST_QUAD);
    wire is_multi3 = (dec_kind == `MLU_K_TWORD) |
                     (dec_kind == `MLU_K_QWORD);
    wire bad_chk  = ((dec_kind == `MLU_K_DWORD) & dst_odd) |
                    (is_multi3 & dst_nq);
    // Alignment per kind
    reg  mis_chk;
    always @* begin
        mis_chk = 1'b0;
        case (dec_kind)
            // Word, halfword and double alignment
            `MLU_K_WORD:  mis_chk = |(eff_addr_in & `MLU_ALIGN_WORD);
            `MLU_K_UHALF,
            `MLU_K_SHALF: mis_chk = |(eff_addr_in & `MLU_ALIGN_HALF);
            `MLU_K_DWORD: mis_chk = |(eff_addr_in & `MLU_ALIGN_DWORD);
            // triple and quad need 16 bytes
            `MLU_K_TWORD,
            `MLU_K_QWORD: mis_chk = |(eff_addr_in & `MLU_ALIGN_QUAD);
            // Bytes and address load never fault
            default:      mis_chk = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Next state logic
    // ----------------------------------------
    always @* begin
        state_next = state_reg;
        kind_next  = kind_reg;
        left_next  = left_reg;
        addr_next  = addr_reg;
        reg_next   = reg_reg;
        mis_next   = mis_reg;
        req_next   = req_reg;
        we_next    = 1'b0;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        done_next  = 1'b0;
        bad_next   = 1'b0;
        misf_next  = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (issue_valid_in && dec_kind != `MLU_K_NONE) begin
                    kind_next = dec_kind;
                    if (dec_kind == `MLU_K_ADDR) begin
                        we_next    = 1'b1;
                        waddr_next = dst_reg_in;
                        wdata_next = eff_addr_in;
                        done_next  = 1'b1;
                    end else if (bad_chk) begin
                        bad_next  = 1'b1;
                        done_next = 1'b1;
                    end else begin
                        // Start memory reads
                        left_next  = dec_count;
                        addr_next  = eff_addr_in;
                        reg_next   = dst_reg_in;
                        mis_next   = mis_chk & unaligned_en_in;
                        req_next   = 1'b1;
                        state_next = ST_READ;
                    end
                end
            end
            ST_READ: begin
                // One register per acknowledge
                if (mem_ack_in) begin
                    we_next    = 1'b1;
                    waddr_next = reg_reg;
                    wdata_next = ext_data;
                    reg_next   = reg_reg + `MLU_REG_STEP;
                    // next word at address plus four
                    addr_next  = addr_reg + `MLU_WORD_STEP;
                    left_next  = left_reg - `MLU_CNT_ONE;
                    // Last word drops the request
                    if (left_reg == `MLU_CNT_ONE) begin
                        req_next   = 1'b0;
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                // Report misalign after data is written
                misf_next  = mis_reg;
                done_next  = 1'b1;
                mis_next   = 1'b0;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
                req_next   = 1'b0;
            end
        endcase
        // Busy follows the state being entered
        busy_next = (state_next != ST_IDLE);
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always @(posedge ref_clk_in) begin
        // Synchronous reset clears all state
        if (!nrst_in) begin
            state_reg <= ST_IDLE;
            kind_reg  <= `MLU_K_NONE;
            left_reg  <= 3'h0;
            addr_reg  <= 32'h0000_0000;
            reg_reg   <= 5'h00;
            mis_reg   <= 1'b0;
            req_reg   <= 1'b0;
            we_reg    <= 1'b0;
            waddr_reg <= 5'h00;
            wdata_reg <= 32'h0000_0000;
            done_reg  <= 1'b0;
            bad_reg   <= 1'b0;
            misf_reg  <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            // Take the next values
            state_reg <= state_next;
            kind_reg  <= kind_next;
            left_reg  <= left_next;
            addr_reg  <= addr_next;
            reg_reg   <= reg_next;
            mis_reg   <= mis_next;
            req_reg   <= req_next;
            we_reg    <= we_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            done_reg  <= done_next;
            bad_reg   <= bad_next;
            misf_reg  <= misf_next;
            busy_reg  <= busy_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // All outputs straight from registers
    assign mem_req_out  = req_reg;
    assign mem_addr_out = addr_reg;
    assign rf_we_out    = we_reg;
    assign rf_waddr_out = waddr_reg;
    assign rf_wdata_out = wdata_reg;
    assign busy_out     = busy_reg;
    assign done_out     = done_reg;
    assign bad_operand_fault_out       = bad_reg;
    assign misaligned_access_fault_out = misf_reg;
endmodule

// ### bench/mlu_mem_model.sv
`timescale 1ns/1ps
module mlu_mem_model (
    // Clock and request
    input  wire        clk_in,
    input  wire        req_in,
    input  wire [31:0] addr_in,
    input  wire        slow_in,
    // Answer
    output reg         ack_out,
    output reg  [31:0] data_out
);
    reg [1:0] wait_reg; // Stall counter
    initial begin
        ack_out = 1'b0;
        data_out = 32'h00000000;
        wait_reg = 2'h0;
    end
    // ----
    // One word per ack, junk in between
    // ----
    always @(posedge clk_in) begin
        if (req_in && !ack_out && wait_reg == 2'h0) begin
            ack_out <= #1 1'b1;
            data_out <= #1 {~addr_in[15:0], addr_in[15:0]};
            wait_reg <= slow_in ? 2'h3 : 2'h0;
        end else begin
            ack_out <= #1 1'b0;
            data_out <= #1 ~data_out;
            if (req_in && wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end
        end
    end
endmodule

// ### bench/mlu_load_props.sv
`timescale 1ns/1ps
`include "mlu_map.vh"
module mlu_load_props (
    // Clock, reset, issue
    input wire        ref_clk_in,
    input wire        nrst_in,
    input wire        issue_valid_in,
    input wire [7:0]  opcode_in,
    input wire [4:0]  dst_reg_in,
    input wire [31:0] eff_addr_in,
    // Memory and register file
    input wire        mem_req_out,
    input wire [31:0] mem_addr_out,
    input wire        mem_ack_in,
    input wire        rf_we_out,
    input wire [31:0] rf_wdata_out,
    // Status
    input wire        done_out,
    input wire        busy_out,
    input wire        bad_operand_fault_out,
    input wire        misaligned_access_fault_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    wire       take = issue_valid_in && !busy_out; // Accepted issue
    reg  [7:0] op_reg;                             // Opcode in flight
    // Track last accepted opcode
    always @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            op_reg <= 8'h00;
        end else if (take) begin
            op_reg <= opcode_in;
        end
    end
    a_lda_writes: assert property (
        take && opcode_in == `MLU_OP_ADDR |=> rf_we_out && !mem_req_out
        && rf_wdata_out == $past(eff_addr_in)) else $error("lda bad");
    a_dword_odd: assert property (
        take && opcode_in == `MLU_OP_DWORD && dst_reg_in[0]
        |=> bad_operand_fault_out && done_out) else $error("odd dst");
    a_quad_dst: assert property (
        take && (opcode_in == `MLU_OP_TWORD || opcode_in == `MLU_OP_QWORD)
        && dst_reg_in[1:0] != 2'h0 |=> bad_operand_fault_out)
        else $error("quad dst");
    a_fault_silent: assert property (
        bad_operand_fault_out |-> !mem_req_out && !rf_we_out)
        else $error("fault access");
    a_word_req: assert property (
        take && opcode_in == `MLU_OP_WORD |=> mem_req_out
        && mem_addr_out == $past(eff_addr_in)) else $error("no req");
    a_addr_step: assert property (
        mem_req_out && mem_ack_in ##1 mem_req_out
        |-> mem_addr_out == $past(mem_addr_out) + 32'h4)
        else $error("step");
    a_ack_write: assert property (
        mem_req_out && mem_ack_in |=> rf_we_out) else $error("no write");
    a_shalf_sign: assert property (
        rf_we_out && op_reg == `MLU_OP_SHALF
        |-> rf_wdata_out[31:16] == {16{rf_wdata_out[15]}})
        else $error("sign");
    a_byte_zero: assert property (
        rf_we_out && op_reg == `MLU_OP_UBYTE |-> rf_wdata_out[31:8] == 24'h0)
        else $error("zero");
    a_misf_done: assert property (
        misaligned_access_fault_out |-> done_out && !busy_out)
        else $error("misalign without done");
    cover property (take && opcode_in == `MLU_OP_QWORD);
    cover property (misaligned_access_fault_out);
    cover property (bad_operand_fault_out);
endmodule
bind mlu_load_unit mlu_load_props u_props (.ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in), .issue_valid_in(issue_valid_in),
    .opcode_in(opcode_in), .dst_reg_in(dst_reg_in),
    .eff_addr_in(eff_addr_in), .mem_req_out(mem_req_out),
    .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in),
    .rf_we_out(rf_we_out), .rf_wdata_out(rf_wdata_out),
    .done_out(done_out), .busy_out(busy_out),
    .bad_operand_fault_out(bad_operand_fault_out),
    .misaligned_access_fault_out(misaligned_access_fault_out));

// ### bench/tb.sv
`timescale 1ns/1ps
`include "mlu_map.vh"
module tb;
    reg         ref_clk_in = 1'b0;  // Core clock
    reg         nrst_in = 1'b0;     // Reset, active low
    reg         issue_valid_in = 1'b0;
    reg  [7:0]  opcode_in = 8'h00;
    reg  [4:0]  dst_reg_in = 5'h00;
    reg  [31:0] eff_addr_in = 32'h0;
    reg         unaligned_en_in = 1'b0;
    reg         slow = 1'b0;        // Memory stall select
    wire        req, ack, we, busy, done, badf, misf;
    wire [31:0] maddr, mdata, wdata;
    wire [4:0]  waddr;
    integer     fails = 0;
    integer     n_checks = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    mlu_load_unit dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .issue_valid_in(issue_valid_in), .opcode_in(opcode_in),
        .dst_reg_in(dst_reg_in), .eff_addr_in(eff_addr_in),
        .unaligned_en_in(unaligned_en_in), .mem_req_out(req),
        .mem_addr_out(maddr), .mem_ack_in(ack), .mem_data_in(mdata),
        .rf_we_out(we), .rf_waddr_out(waddr), .rf_wdata_out(wdata),
        .busy_out(busy), .done_out(done), .bad_operand_fault_out(badf),
        .misaligned_access_fault_out(misf));
    mlu_mem_model mem (.clk_in(ref_clk_in), .req_in(req),
        .addr_in(maddr), .slow_in(slow), .ack_out(ack), .data_out(mdata));
    // Verdict and end of run
    task close_out;
        begin
            if (fails == 0 && n_checks > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    // Compare one value
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Expected register word for an opcode
    function [31:0] xd(input [7:0] op, input [31:0] a);
        reg [31:0] w;
        begin
            w = {~a[15:0], a[15:0]};
            case (op)
                `MLU_OP_UBYTE: xd = {24'h000000, w[7:0]};
                `MLU_OP_SBYTE: xd = {{24{w[7]}}, w[7:0]};
                `MLU_OP_UHALF: xd = {16'h0000, w[15:0]};
                `MLU_OP_SHALF: xd = {{16{w[15]}}, w[15:0]};
                `MLU_OP_ADDR:  xd = a;
                default:       xd = w;
            endcase
        end
    endfunction
    // Issue one instruction, judge writes and faults
    task run(input [7:0] op, input [4:0] d, input [31:0] a, input u,
             input [2:0] n, input [1:0] f);
        integer i;
        integer k;
        reg     seen;
        begin
            k = 0;
            seen = 1'b0;
            opcode_in = op;
            dst_reg_in = d;
            eff_addr_in = a;
            unaligned_en_in = u;
            issue_valid_in = 1'b1;
            @(posedge ref_clk_in);
            #1 issue_valid_in = 1'b0;
            for (i = 0; i < 60 && !seen; i = i + 1) begin
                if (we === 1'b1) begin
                    chk(waddr, d + k);
                    chk(wdata, xd(op, a + 4 * k));
                    k = k + 1;
                end
                if (f[1]) chk(req, 1'h0);
                if (done === 1'b1) begin
                    seen = 1'b1;
                    chk({badf, misf}, f);
                    chk(k, n);
                end
                @(posedge ref_clk_in);
                #1;
            end
            for (i = 0; i < 9 && busy !== 1'b0; i = i + 1) begin
                @(posedge ref_clk_in);
                #1;
            end
            if (!seen || busy !== 1'b0) begin
                fails = fails + 1;
                close_out;
            end
        end
    endtask
    task t_widen;
        begin
            run(`MLU_OP_UBYTE, 5'h01, 32'h8080, 1'h1, 3'h1, 2'h0);
            run(`MLU_OP_SBYTE, 5'h02, 32'h8080, 1'h1, 3'h1, 2'h0);
            run(`MLU_OP_SBYTE, 5'h02, 32'h1230, 1'h1, 3'h1, 2'h0);
            run(`MLU_OP_UHALF, 5'h03, 32'h8080, 1'h1, 3'h1, 2'h0);
            run(`MLU_OP_SHALF, 5'h04, 32'h8080, 1'h1, 3'h1, 2'h0);
            run(`MLU_OP_SHALF, 5'h05, 32'h1230, 1'h1, 3'h1, 2'h0);
            run(`MLU_OP_WORD, 5'h06, 32'h1230, 1'h1, 3'h1, 2'h0);
            run(`MLU_OP_WORD, 5'h07, 32'h1232, 1'h1, 3'h1, 2'h1);
            run(`MLU_OP_SHALF, 5'h08, 32'h8081, 1'h1, 3'h1, 2'h1);
            run(`MLU_OP_SBYTE, 5'h09, 32'h8081, 1'h1, 3'h1, 2'h0);
        end
    endtask
    task t_multi;
        begin
            slow = 1'b1;
            run(`MLU_OP_DWORD, 5'h04, 32'h100, 1'h1, 3'h2, 2'h0);
            run(`MLU_OP_DWORD, 5'h06, 32'h104, 1'h1, 3'h2, 2'h1);
            run(`MLU_OP_DWORD, 5'h06, 32'h104, 1'h0, 3'h2, 2'h0);
            run(`MLU_OP_TWORD, 5'h08, 32'h208, 1'h1, 3'h3, 2'h1);
            run(`MLU_OP_QWORD, 5'h0C, 32'h300, 1'h1, 3'h4, 2'h0);
            run(`MLU_OP_QWORD, 5'h00, 32'h304, 1'h0, 3'h4, 2'h0);
            slow = 1'b0;
        end
    endtask
    task t_bad;
        begin
            run(`MLU_OP_DWORD, 5'h05, 32'h100, 1'h1, 3'h0, 2'h2);
            run(`MLU_OP_TWORD, 5'h06, 32'h200, 1'h1, 3'h0, 2'h2);
            run(`MLU_OP_QWORD, 5'h02, 32'h300, 1'h1, 3'h0, 2'h2);
        end
    endtask
    task t_lda;
        begin
            // Odd address taken unchecked
            run(`MLU_OP_ADDR, 5'h03, 32'hDEADBEEF, 1'h1, 3'h1, 2'h0);
        end
    endtask
    // Issue refused while busy, then reset in mid-load
    task t_reset;
        begin
            opcode_in = `MLU_OP_QWORD;
            dst_reg_in = 5'h00;
            eff_addr_in = 32'h400;
            issue_valid_in = 1'b1;
            @(posedge ref_clk_in);
            #1 opcode_in = `MLU_OP_ADDR;
            @(posedge ref_clk_in);
            #1 chk(we, 1'h0);
            issue_valid_in = 1'b0;
            nrst_in = 1'b0;
            @(posedge ref_clk_in);
            #1 chk({req, we, busy, done}, 4'h0);
            @(posedge ref_clk_in);
            #1 nrst_in = 1'b1;
            @(posedge ref_clk_in);
            #1 chk({req, busy, badf, misf}, 4'h0);
            run(`MLU_OP_QWORD, 5'h00, 32'h400, 1'h1, 3'h4, 2'h0);
        end
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk_in);
        #1 nrst_in = 1'b1;
        @(posedge ref_clk_in);
        #1;
        t_widen;
        t_multi;
        t_bad;
        t_lda;
        t_reset;
        close_out;
    end
endmodule
